// file: verilog/run_ctl_map.vh
`ifndef RUN_CTL_MAP_VH
`define RUN_CTL_MAP_VH
// ==========================================================
// register byte addresses
`define ADDR_COMMAND     4'h0
`define ADDR_STATUS      4'h4
`define ADDR_PORT_STATUS 4'h8
// ==========================================================
// command register fields
`define CMD_RUN_BIT      0
`define CMD_RESET_BIT    1
`define CMD_DEBUG_BIT    5
`define CMD_RESET_VALUE  16'h0000
// ==========================================================
// status register fields
`define STS_SYSERR_BIT   3
`define STS_PROCERR_BIT  4
`define STS_HALTED_BIT   5
// ==========================================================
// port status/control fields
`define PSC_CONNECT_BIT  0
`define PSC_CONN_CHG_BIT 1
`define PSC_ENABLE_BIT   2
`define PSC_EN_CHG_BIT   3
`define PSC_LOWSPEED_BIT 8
// ==========================================================
// timing
`define BIT_TIME_NS      83
`define DETECT_BIT_TIMES 64
`define CLK_PERIOD_NS    20
`define RESET_CYCLES     4
`define SOF_PERIOD_CYCLES 50000
`endif

// file: verilog/run_reset_ctl.v
`timescale 1ns/1ps
`include "run_ctl_map.vh"
// Behaviour
// - soft reset clears timers, machines, aborts transaction
// - hardware clears soft-reset bit when done
// - soft reset touches port bits 8,3:0 only
// - reset forces virtual disconnect, port disabled
// - disconnect sets change flags, clears low-speed
// - redetect connect and speed 64 bit times later
// - run bit set keeps schedule executing
// - run cleared: finish transaction, halt, flag
// - fatal errors clear run bit
// - normal stop resets frame counter
// - normal mode runs until run cleared
// - debug stop freezes counter, resumes later
// - debug: fetch clears run, execute, halt
// - debug skips inactive descriptors
// - debug end of frame waits next SOF
// - halted flag set on stop, write-one clear
// - host bus error sets flag, stops run
module run_reset_ctl #(
	parameter SOF_CYCLES = `SOF_PERIOD_CYCLES,
	parameter NPORTS     = 2
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [3:0]        s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [3:0]        s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              desc_fetched,
	input  wire              desc_active,
	input  wire              desc_done,
	input  wire              frame_has_more,
	input  wire              consistency_error,
	input  wire              host_bus_error,
	input  wire [NPORTS-1:0] port_attached,
	input  wire [NPORTS-1:0] port_low_speed,
	output reg               schedule_run,
	output reg               transaction_abort,
	output reg               start_of_frame,
	output reg               frame_count_clear,
	output reg  [NPORTS-1:0] port_connect
);
	localparam DETECT_NS     = `DETECT_BIT_TIMES * `BIT_TIME_NS;
	localparam DETECT_CYCLES = DETECT_NS / `CLK_PERIOD_NS;
	localparam ST_STOP  = 3'd0;
	localparam ST_RUN   = 3'd1;
	localparam ST_XFER  = 3'd2;
	localparam ST_WSOF  = 3'd3;
	localparam ST_WFET  = 3'd4;

	reg  [15:0] cmd_reg;
	reg  [5:0]  sts_reg;
	reg  [2:0]  state_reg;
	reg  [15:0] sof_cnt_reg;
	reg  [3:0]  rst_cnt_reg;
	reg  [9:0]  det_cnt_reg;
	reg         det_pend_reg;
	reg  [NPORTS*16-1:0] psc_reg;
	reg         aw_hold_reg;
	reg         w_hold_reg;
	reg  [3:0]  awaddr_reg;
	reg  [31:0] wdata_reg;
	reg  [3:0]  wstrb_reg;

	wire run      = cmd_reg[`CMD_RUN_BIT];
	wire debug    = cmd_reg[`CMD_DEBUG_BIT];
	wire soft_rst = cmd_reg[`CMD_RESET_BIT];
	wire do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	wire wr_cmd   = do_write && awaddr_reg == `ADDR_COMMAND && wstrb_reg[0];
	wire wr_sts   = do_write && awaddr_reg == `ADDR_STATUS && wstrb_reg[0];
	wire fatal    = consistency_error || host_bus_error;
	// the frame timer keeps ticking through a debug step, so the end-of-frame wait always ends
	wire sof_tick = state_reg != ST_STOP && sof_cnt_reg == SOF_CYCLES - 1;
	// debug step: the fetch of an active descriptor drops run
	wire step_fetch = debug && desc_fetched && desc_active && state_reg == ST_RUN;

	// ==========================================================
	// axi write channel: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			awaddr_reg    <= 4'h0;
			wdata_reg     <= 32'h00000000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
		end else begin
			s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg  <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				// unmapped addresses answer with a slave error
				s_axi_bresp  <= (awaddr_reg == `ADDR_COMMAND || awaddr_reg == `ADDR_STATUS ||
					awaddr_reg == `ADDR_PORT_STATUS) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
			end
		end
	end

	// ==========================================================
	// axi read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				case ({s_axi_araddr[3:2], 2'b00})
					`ADDR_COMMAND:     s_axi_rdata <= {16'h0000, cmd_reg};
					`ADDR_STATUS:      s_axi_rdata <= {26'h0000000, sts_reg};
					`ADDR_PORT_STATUS: s_axi_rdata <= {16'h0000, psc_reg[15:0]};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// command register, soft reset sequencing and run control
	always @(posedge aclk) begin
		if (!aresetn) begin
			cmd_reg     <= `CMD_RESET_VALUE;
			rst_cnt_reg <= 4'h0;
		end else begin
			if (wr_cmd) begin
				cmd_reg[7:0] <= wdata_reg[7:0];
				// a written zero cannot cut a running reset short
				cmd_reg[`CMD_RESET_BIT] <= soft_rst | wdata_reg[`CMD_RESET_BIT];
				if (wstrb_reg[1])
					cmd_reg[15:8] <= wdata_reg[15:8];
			end
			if (soft_rst) begin
				rst_cnt_reg <= rst_cnt_reg + 4'h1;
				cmd_reg[`CMD_RUN_BIT] <= 1'b0;
				if (rst_cnt_reg == `RESET_CYCLES - 1) begin
					cmd_reg[`CMD_RESET_BIT] <= 1'b0;
					rst_cnt_reg <= 4'h0;
				end
			end
			// hardware clear wins over a software set in the same cycle
			if (fatal)
				cmd_reg[`CMD_RUN_BIT] <= 1'b0;
			if (step_fetch)
				cmd_reg[`CMD_RUN_BIT] <= 1'b0;
		end
	end

	// ==========================================================
	// status flags: hardware set beats write-one clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			sts_reg <= 6'h20;
		end else begin
			if (wr_sts)
				sts_reg <= sts_reg & ~wdata_reg[5:0];
			if (host_bus_error)
				sts_reg[`STS_SYSERR_BIT] <= 1'b1;
			if (consistency_error)
				sts_reg[`STS_PROCERR_BIT] <= 1'b1;
			if (state_reg == ST_RUN && !run && !step_fetch)
				sts_reg[`STS_HALTED_BIT] <= 1'b1;
			// at the end of a frame a debug step halts only after the next fetch
			if (state_reg == ST_XFER && desc_done && !run && !(debug && !frame_has_more))
				sts_reg[`STS_HALTED_BIT] <= 1'b1;
			if (state_reg == ST_WFET && desc_fetched && debug)
				sts_reg[`STS_HALTED_BIT] <= 1'b1;
		end
	end

	// ==========================================================
	// schedule machine and frame counter
	always @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			state_reg         <= ST_STOP;
			sof_cnt_reg       <= 16'h0000;
			schedule_run      <= 1'b0;
			// a single abort pulse on the first cycle of a soft reset
			transaction_abort <= aresetn && rst_cnt_reg == 4'h0;
			start_of_frame    <= 1'b0;
			frame_count_clear <= 1'b0;
		end else begin
			transaction_abort <= 1'b0;
			start_of_frame    <= sof_tick;
			frame_count_clear <= 1'b0;
			if (state_reg != ST_STOP && state_reg != ST_WSOF)
				sof_cnt_reg <= sof_tick ? 16'h0000 : sof_cnt_reg + 16'h0001;
			case (state_reg)
				ST_STOP: begin
					schedule_run <= 1'b0;
					if (run) begin
						state_reg    <= ST_RUN;
						schedule_run <= 1'b1;
					end
				end
				ST_RUN: begin
					if (!run && !step_fetch) begin
						state_reg <= ST_STOP;
						schedule_run <= 1'b0;
						if (!debug) begin
							sof_cnt_reg       <= 16'h0000;
							frame_count_clear <= 1'b1;
						end // debug keeps the counter frozen
					end else if (desc_fetched && desc_active) begin
						state_reg <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (desc_done) begin
						if (debug && !frame_has_more)
							state_reg <= ST_WSOF;
						else if (!run) begin
							state_reg <= ST_STOP;
							schedule_run <= 1'b0;
							if (!debug)
								frame_count_clear <= 1'b1;
						end else
							state_reg <= ST_RUN;
					end
				end
				ST_WSOF: begin
					sof_cnt_reg <= sof_tick ? 16'h0000 : sof_cnt_reg + 16'h0001;
					if (sof_cnt_reg == SOF_CYCLES - 1)
						state_reg <= ST_WFET;
				end
				ST_WFET: begin
					if (desc_fetched) begin
						state_reg    <= ST_STOP;
						schedule_run <= 1'b0;
					end
				end
				default: state_reg <= ST_STOP;
			endcase
			if (state_reg == ST_STOP && !run)
				schedule_run <= 1'b0;
		end
	end

	// ==========================================================
	// redetect timer after soft reset ends
	always @(posedge aclk) begin
		if (!aresetn) begin
			det_cnt_reg  <= 10'h000;
			det_pend_reg <= 1'b0;
		end else if (soft_rst) begin
			det_cnt_reg  <= 10'h000;
			det_pend_reg <= 1'b1;
		end else if (det_pend_reg) begin
			det_cnt_reg <= det_cnt_reg + 10'h001;
			if (det_cnt_reg == DETECT_CYCLES[9:0] - 10'h001)
				det_pend_reg <= 1'b0;
		end
	end

	// ==========================================================
	// per-port status/control; only bits 8 and 3:0 see the soft reset
	genvar p;
	generate
		for (p = 0; p < NPORTS; p = p + 1) begin : g_port
			always @(posedge aclk) begin
				if (!aresetn) begin
					psc_reg[p*16 +: 16] <= 16'h0000;
					port_connect[p]     <= 1'b0;
				end else if (soft_rst) begin
					port_connect[p] <= 1'b0;
					psc_reg[p*16 + `PSC_CONNECT_BIT]  <= 1'b0;
					psc_reg[p*16 + `PSC_ENABLE_BIT]   <= 1'b0;
					psc_reg[p*16 + `PSC_CONN_CHG_BIT] <= 1'b1;
					psc_reg[p*16 + `PSC_EN_CHG_BIT]   <= 1'b1;
					psc_reg[p*16 + `PSC_LOWSPEED_BIT] <= 1'b0;
				end else if (det_pend_reg && det_cnt_reg == DETECT_CYCLES[9:0] - 10'h001) begin
					port_connect[p] <= port_attached[p];
					psc_reg[p*16 + `PSC_CONNECT_BIT]  <= port_attached[p];
					psc_reg[p*16 + `PSC_LOWSPEED_BIT] <= port_low_speed[p];
				end
			end
		end
	endgenerate
endmodule // run_reset_ctl

// file: verification/run_reset_ctl_monitor.sv
`timescale 1ns/1ps
// ========================================
// port checks for the run and reset control
module run_reset_ctl_monitor #(
	parameter NPORTS = 2
) (
	input wire              aclk,
	input wire              aresetn,
	input wire              host_bus_error,
	input wire              consistency_error,
	input wire              schedule_run,
	input wire              transaction_abort,
	input wire              start_of_frame,
	input wire              frame_count_clear,
	input wire [NPORTS-1:0] port_connect
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// soft reset steps: abort first, then ports held disconnected
	sequence s_abort;
		transaction_abort;
	endsequence
	sequence s_disc;
		(port_connect == '0) [*8];
	endsequence
	// two idle cycles mean the engine has really stopped
	sequence s_stopped;
		!schedule_run ##1 !schedule_run;
	endsequence
	AST_RST_DISC: assert property (s_abort |-> ##2 s_disc) else $error("port connected after soft reset");
	AST_ABORT_PULSE: assert property (s_abort |=> !transaction_abort) else $error("abort not a pulse");
	AST_RST_STOP: assert property (s_abort |-> ##[0:2] !schedule_run) else $error("run kept in reset");
	AST_HBE_STOP: assert property (host_bus_error |-> ##[1:4] !schedule_run) else $error("bus error kept run");
	AST_CCF_STOP: assert property (consistency_error |-> ##[1:4] !schedule_run) else $error("check fail kept run");
	AST_SOF_RUN: assert property (start_of_frame |-> schedule_run || $past(schedule_run)) else $error("sof when idle");
	AST_SOF_GAP: assert property (start_of_frame |=> !start_of_frame [*8]) else $error("sof too close");
	AST_FCLR_STOP: assert property (frame_count_clear |-> !schedule_run) else $error("clear while running");
	AST_STOP_NO_SOF: assert property (s_stopped |-> !start_of_frame) else $error("sof after stop");
endmodule // run_reset_ctl_monitor

bind run_reset_ctl run_reset_ctl_monitor #(.NPORTS(NPORTS)) mon_u (
	.aclk(aclk), .aresetn(aresetn), .host_bus_error(host_bus_error),
	.consistency_error(consistency_error), .schedule_run(schedule_run),
	.transaction_abort(transaction_abort), .start_of_frame(start_of_frame),
	.frame_count_clear(frame_count_clear), .port_connect(port_connect));

// file: verification/usb_port_devices.sv
`timescale 1ns/1ps
// ========================================
// downstream devices seen as attach and speed levels
module usb_port_devices #(
	parameter NPORTS = 2
) (
	input  wire              aclk,
	input  wire [NPORTS-1:0] plug,
	input  wire [NPORTS-1:0] slow,
	output reg  [NPORTS-1:0] port_attached = '0,
	output reg  [NPORTS-1:0] port_low_speed = '0
);
	// an empty port has no speed pull-up, so speed reads 0 there
	always @(posedge aclk) begin
		port_attached <= plug;
		port_low_speed <= plug & slow;
	end
endmodule // usb_port_devices

// file: verification/usb_host_run_reset_debug_ctl_bench.sv
`timescale 1ns/1ps
// ========================================
// bench: register tasks and run/stop, debug, reset tests
module usb_host_run_reset_debug_ctl_bench;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, ev = 4'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, desc_active = 1'h0, frame_has_more = 1'h1;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [1:0]  plug = 2'h3, slow = 2'h1, last_resp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp, port_attached, port_low_speed, port_connect;
	wire [31:0]  s_axi_rdata;
	wire         desc_fetched, desc_done, consistency_error, host_bus_error;
	wire         schedule_run, transaction_abort, start_of_frame, frame_count_clear;
	int          mismatches = 0, compares = 0, cycles = 0, sofs = 0, clrs = 0, aborts = 0;
	assign {consistency_error, host_bus_error, desc_done, desc_fetched} = ev;

	run_reset_ctl #(.SOF_CYCLES(50), .NPORTS(2)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .desc_fetched, .desc_active, .desc_done, .frame_has_more,
		.consistency_error, .host_bus_error, .port_attached, .port_low_speed, .schedule_run,
		.transaction_abort, .start_of_frame, .frame_count_clear, .port_connect);
	usb_port_devices #(.NPORTS(2)) dev_u (.aclk, .plug, .slow, .port_attached, .port_low_speed);

	initial begin
		forever #10 aclk = ~aclk;
	end
	// event tallies and the hang limit; a run needs well under 2000 cycles
	always @(posedge aclk) begin
		sofs += start_of_frame;
		clrs += frame_count_clear;
		aborts += transaction_abort;
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			end_of_test();
		end
	end
	// ========================================
	// bus tasks
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		last_resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		// one idle edge so the next call never re-drives a ready in this time step
		@(posedge aclk);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// read one register and compare the masked bits
	task automatic chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		cmp(s_axi_rdata & m, e);
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	// one-cycle strobe on the schedule and error inputs
	task automatic pulse(input logic [3:0] p);
		ev <= p;
		@(posedge aclk);
		ev <= 4'h0;
		@(posedge aclk);
	endtask
	task automatic end_of_test;
		if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ========================================
	// test sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		chk(4'h4, 32'h20, 32'h20);
		chk(4'hC, 32'hFFFFFFFF, 32'h0);
		wr(4'hC, 32'h1);
		cmp(last_resp, 2'h2);
		wr(4'h4, 32'h20);
		wr(4'h0, 32'h1);
		repeat (60) @(posedge aclk);
		cmp(sofs != 0, 1'h1);
		cmp(schedule_run, 1'h1);
		chk(4'h4, 32'h20, 32'h0);
		// normal stop with an empty schedule
		clrs = 0;
		wr(4'h0, 32'h0);
		repeat (4) @(posedge aclk);
		cmp(schedule_run | (clrs == 0), 1'h0);
		chk(4'h4, 32'h20, 32'h20);
		// fatal errors: consistency first, then host bus
		for (int i = 0; i < 2; i++) begin
			wr(4'h4, 32'h38);
			wr(4'h0, 32'h1);
			pulse(i ? 4'h4 : 4'h8);
			repeat (2) @(posedge aclk);
			chk(4'h0, 32'h1, 32'h0);
			chk(4'h4, 32'h38, i ? 32'h28 : 32'h30);
		end
		// single step: inactive descriptor skipped, active one halts
		clrs = 0;
		wr(4'h0, 32'h20);
		wr(4'h4, 32'h38);
		wr(4'h0, 32'h21);
		pulse(4'h1);
		chk(4'h0, 32'h1, 32'h1);
		desc_active <= 1'h1;
		pulse(4'h1);
		chk(4'h0, 32'h1, 32'h0);
		chk(4'h4, 32'h20, 32'h0);
		pulse(4'h2);
		repeat (2) @(posedge aclk);
		chk(4'h4, 32'h20, 32'h20);
		cmp(clrs, 0);
		// last active descriptor of a frame: halt only after the next frame's first fetch
		frame_has_more <= 1'h0;
		wr(4'h4, 32'h20);
		wr(4'h0, 32'h21);
		pulse(4'h1);
		pulse(4'h2);
		chk(4'h4, 32'h20, 32'h0);
		repeat (60) @(posedge aclk);
		pulse(4'h1);
		repeat (2) @(posedge aclk);
		chk(4'h4, 32'h20, 32'h20);
		// soft reset from run; the zero written next lands one cycle after the reset bit self-clears
		wr(4'h0, 32'h0);
		wr(4'h0, 32'h1);
		aborts = 0;
		wr(4'h0, 32'h2);
		wr(4'h0, 32'h0);
		cmp(aborts != 0, 1'h1);
		repeat (8) @(posedge aclk);
		chk(4'h0, 32'h2, 32'h0);
		repeat (300) @(posedge aclk);
		cmp(port_connect, 2'h3);
		chk(4'h8, 32'h101, 32'h101);
		// second reset with devices seen: forced disconnect, change flags, speed cleared
		wr(4'h0, 32'h2);
		cmp(port_connect, 2'h0);
		chk(4'h8, 32'h10B, 32'h00A);
		end_of_test();
	end
endmodule // usb_host_run_reset_debug_ctl_bench
